// ### common/cchc_defs.svh
// Offsets, field positions, reset values and timing constants of the CC hardware control block.
`ifndef CCHC_DEFS_SVH
`define CCHC_DEFS_SVH
`define CCHC_ADDR_HW_CTL 12'h800
`define CCHC_ADDR_STRAP_CFG 12'h804
`define CCHC_ADDR_W 12
`define CCHC_SHORT_HI 15
`define CCHC_SHORT_LO 14
`define CCHC_PAUSE_BIT 12
`define CCHC_UNIT_BIT 11
`define CCHC_MODE_BIT 10
`define CCHC_ACTIVE_BIT 9
`define CCHC_ATTACH_BIT 8
`define CCHC_PWR_HI 7
`define CCHC_PWR_LO 6
`define CCHC_DET_HI 5
`define CCHC_DET_LO 3
`define CCHC_ROLE_BIT 2
`define CCHC_SA_BIT 0
`define CCHC_SHORT_NONE_MSB 1'b0
`define CCHC_SHORT_WAIT 2'b10
`define CCHC_SHORT_WAIT_OR_T 2'b11
`define CCHC_UNIT_SLOW_NS 1600000
`define CCHC_UNIT_FAST_NS 100000
`define CCHC_CLK_NS 100
`define CCHC_RESP_OKAY 2'b00
`define CCHC_RESP_SLVERR 2'b10
`define CCHC_PWR_RESET_NONE 2'h0
`define CCHC_DET_RESET_NONE 3'h0
`define CCHC_CFG_DFP 2'h1
`define CCHC_CFG_SA_UFP 2'h2
`define CCHC_CFG_SA_DFP 2'h3
`define CCHC_BOOT_APPLY 2'h2
`define CCHC_BOOT_DONE 2'h3
`endif

// ### common/cchc_pkg.sv
// Types shared by the CC hardware control block.
package cchc_pkg;
  typedef enum logic [1:0] {
    cchc_dis_idle,
    cchc_dis_wait,
    cchc_dis_on
  } cchc_dis_t;
  typedef struct packed {
    logic [1:0] short_handling_select;
    logic pause_on_message;
    logic match_debounce_unit;
    logic [2:0] detach_select;
    logic port_role;
    logic standalone;
  } cchc_ctl_t;
  typedef struct packed {
    logic debouncer_active_flag;
    logic attached;
    logic [1:0] power_capability_straps;
  } cchc_sts_t;
endpackage

// ### design/cchc_ctrl.sv
// CC hardware control register with AXI4-Lite access and standalone discharge sequencing.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cchc_defs.svh"
module cchc_ctrl
  import cchc_pkg::*;
#(
  parameter bit HAS_PWR_PINS = 1'b1,
  parameter int unsigned CYCLE_PERIOD_NS = 1600000,
  parameter int unsigned CYCLE_CNT = (CYCLE_PERIOD_NS / `CCHC_CLK_NS) > 0 ?
    (CYCLE_PERIOD_NS / `CCHC_CLK_NS) : 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] cfg_sel_pins,
  input wire logic [1:0] power_capability_straps,
  input wire logic message_seen,
  input wire logic attach_seen,
  input wire logic detach_seen,
  input wire logic orientation_seen,
  input wire logic short_present,
  input wire logic discharge_request,
  output logic debouncer_enable,
  output logic debouncer_pause,
  output logic [2:0] detach_threshold_select,
  output logic [31:0] match_unit_cycles,
  output logic port_role_dfp,
  output logic vconn_enable,
  output logic attach_out,
  output logic orientation_out,
  output logic discharge_start
);
  localparam int unsigned SLOW_CYC = `CCHC_UNIT_SLOW_NS / `CCHC_CLK_NS;
  localparam int unsigned FAST_CYC = `CCHC_UNIT_FAST_NS / `CCHC_CLK_NS;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    cchc_ctl_t ctl;
    logic attached;
    logic orient;
    logic [1:0] boot;
    logic [1:0] cfg_s1;
    logic [1:0] cfg_s2;
    logic [1:0] pwr_s1;
    logic [1:0] pwr_s2;
    logic [1:0] sh_s;
    logic [1:0] at_s1;
    logic [1:0] at_s2;
    logic [1:0] msg_s;
    logic [1:0] or_s;
    logic [1:0] req_s;
    cchc_dis_t dis;
    logic [31:0] tcnt;
    logic aw_got;
    logic [11:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cchc_state_t;

  cchc_state_t st;
  cchc_state_t next_st;
  logic sa_dfp;
  logic [15:0] reg_view;

  always_comb begin
    // Standalone DFP is the only configuration in which short handling acts.
    sa_dfp = st.ctl.standalone && st.ctl.port_role;
    reg_view = 16'h0000;
    reg_view[`CCHC_SHORT_HI:`CCHC_SHORT_LO] = st.ctl.short_handling_select;
    reg_view[`CCHC_PAUSE_BIT] = st.ctl.pause_on_message;
    reg_view[`CCHC_UNIT_BIT] = st.ctl.match_debounce_unit;
    reg_view[`CCHC_MODE_BIT] = st.ctl.standalone;
    reg_view[`CCHC_ACTIVE_BIT] = st.ctl.standalone;
    reg_view[`CCHC_ATTACH_BIT] = st.attached;
    reg_view[`CCHC_PWR_HI:`CCHC_PWR_LO] = HAS_PWR_PINS ? st.pwr_s2 : `CCHC_PWR_RESET_NONE;
    reg_view[`CCHC_DET_HI:`CCHC_DET_LO] = st.ctl.detach_select;
    reg_view[`CCHC_ROLE_BIT] = st.ctl.port_role;
    reg_view[`CCHC_SA_BIT] = st.ctl.standalone;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.cfg_s1 = cfg_sel_pins;
    next_st.cfg_s2 = st.cfg_s1;
    next_st.pwr_s1 = power_capability_straps;
    next_st.pwr_s2 = st.pwr_s1;
    next_st.sh_s = {st.sh_s[0], short_present};
    next_st.at_s1 = {attach_seen, detach_seen};
    next_st.at_s2 = st.at_s1;
    next_st.msg_s = {st.msg_s[0], message_seen};
    // Orientation is a pin too; two stages keep it aligned with the attach sync.
    next_st.or_s = {st.or_s[0], orientation_seen};
    next_st.req_s = {st.req_s[0], discharge_request};
    // Straps are only trusted once they have passed the synchroniser.
    if (st.boot != `CCHC_BOOT_DONE) begin
      next_st.boot = st.boot + 2'h1;
      if (st.boot == `CCHC_BOOT_APPLY) begin
        next_st.ctl.standalone = (st.cfg_s2 == `CCHC_CFG_SA_UFP) ||
          (st.cfg_s2 == `CCHC_CFG_SA_DFP);
        next_st.ctl.port_role = (st.cfg_s2 == `CCHC_CFG_DFP) ||
          (st.cfg_s2 == `CCHC_CFG_SA_DFP);
        next_st.ctl.detach_select = HAS_PWR_PINS ? {1'b0, st.pwr_s2} :
          `CCHC_DET_RESET_NONE;
      end
    end
    // Attach tracking only runs while the internal logic owns the port.
    if (!st.ctl.standalone) begin
      next_st.attached = 1'b0;
    end else if (st.at_s2[1]) begin
      next_st.attached = 1'b1;
      next_st.orient = st.or_s[1];
    end else if (st.at_s2[0]) begin
      next_st.attached = 1'b0;
    end
    // Discharge sequencing.
    case (st.dis)
      cchc_dis_idle: begin
        next_st.tcnt = 32'h0;
        if (sa_dfp && st.req_s[1]) begin
          if (st.ctl.short_handling_select[1] == `CCHC_SHORT_NONE_MSB) begin
            next_st.dis = cchc_dis_on;
          end else begin
            next_st.dis = cchc_dis_wait;
          end
        end
      end
      cchc_dis_wait: begin
        next_st.tcnt = st.tcnt + 32'h1;
        if (!sa_dfp) begin
          next_st.dis = cchc_dis_idle;
        end else if (!st.sh_s[1]) begin
          next_st.dis = cchc_dis_on;
        end else if (st.ctl.short_handling_select == `CCHC_SHORT_WAIT_OR_T &&
            st.tcnt >= 32'(CYCLE_CNT - 1)) begin
          next_st.dis = cchc_dis_on;
        end
      end
      cchc_dis_on: begin
        next_st.dis = cchc_dis_idle;
      end
      default: begin
        next_st.dis = cchc_dis_idle;
      end
    endcase
    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `CCHC_RESP_OKAY;
      if (st.awaddr == `CCHC_ADDR_HW_CTL) begin
        if (st.wstrb[0]) begin
          next_st.ctl.detach_select = st.wdata[`CCHC_DET_HI:`CCHC_DET_LO];
          next_st.ctl.port_role = st.wdata[`CCHC_ROLE_BIT];
          next_st.ctl.standalone = st.wdata[`CCHC_SA_BIT];
        end
        if (st.wstrb[1]) begin
          next_st.ctl.short_handling_select = st.wdata[`CCHC_SHORT_HI:`CCHC_SHORT_LO];
          next_st.ctl.pause_on_message = st.wdata[`CCHC_PAUSE_BIT];
          next_st.ctl.match_debounce_unit = st.wdata[`CCHC_UNIT_BIT];
        end
      end else begin
        next_st.bresp = `CCHC_RESP_SLVERR;
      end
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `CCHC_RESP_OKAY;
      next_st.rdata = 32'h0;
      if (s_axi_araddr == `CCHC_ADDR_HW_CTL) begin
        next_st.rdata = {16'h0000, reg_view};
      end else if (s_axi_araddr == `CCHC_ADDR_STRAP_CFG) begin
        next_st.rdata = {30'h0, st.cfg_s2};
      end else begin
        next_st.rresp = `CCHC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.dis <= cchc_dis_idle;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready = !st.aw_got;
  assign s_axi_wready = !st.w_got;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign debouncer_enable = st.ctl.standalone;
  // Pausing is a plain gate; the debouncer resumes as soon as the message ends.
  assign debouncer_pause = st.ctl.pause_on_message && st.msg_s[1];
  assign detach_threshold_select = st.ctl.detach_select;
  assign match_unit_cycles = st.ctl.match_debounce_unit ? 32'(FAST_CYC) : 32'(SLOW_CYC);
  assign port_role_dfp = st.ctl.port_role;
  assign vconn_enable = st.ctl.standalone && st.attached;
  assign attach_out = st.attached;
  assign orientation_out = st.orient;
  assign discharge_start = (st.dis == cchc_dis_on);

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_req_sa_dfp;
    sa_dfp && st.dis == cchc_dis_idle && st.req_s[1];
  endsequence
  a_short_none_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_req_sa_dfp and !st.ctl.short_handling_select[1]) |=> discharge_start)
    else $error("Discharge did not start at once.");
  a_short_wait_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    st.dis == cchc_dis_wait && st.ctl.short_handling_select == `CCHC_SHORT_WAIT &&
    st.sh_s[1] |=> !discharge_start)
    else $error("Discharge started during short.");
  a_short_clear_go: assert property (@(posedge aclk) disable iff (!aresetn)
    st.dis == cchc_dis_wait && sa_dfp && !st.sh_s[1] |=> discharge_start)
    else $error("Discharge missed the short clear.");
  a_short_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    !sa_dfp |=> !discharge_start)
    else $error("Discharge outside standalone DFP.");
  a_pause_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    debouncer_pause |-> st.ctl.pause_on_message && $past(st.msg_s[0]))
    else $error("Pause without enable and message.");
  a_unit_cycles: assert property (@(posedge aclk) disable iff (!aresetn)
    match_unit_cycles == (st.ctl.match_debounce_unit ? 32'h3e8 : 32'h3e80))
    else $error("Wrong debounce unit.");
  a_mode_view: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_view[`CCHC_MODE_BIT] == debouncer_enable && reg_view[`CCHC_ACTIVE_BIT] == debouncer_enable)
    else $error("Mode view mismatch.");
  a_attach_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    !st.ctl.standalone |=> !attach_out)
    else $error("Attached outside standalone.");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `CCHC_ADDR_HW_CTL |=>
    s_axi_rdata[13] == 1'b0 && s_axi_rdata[1] == 1'b0)
    else $error("Reserved bit read nonzero.");
endmodule // cchc_ctrl

// ### testbench/cchc_port_model.sv
// Port partner model: drives the CC detect, message, short and discharge pins.
`timescale 1ns/1ps
module cchc_port_model (
  input wire logic aclk,
  input wire logic [5:0] want,
  output logic discharge_request,
  output logic detach_seen,
  output logic message_seen,
  output logic attach_seen,
  output logic orientation_seen,
  output logic short_present
);
  initial begin
    {discharge_request, detach_seen, message_seen} = 3'h0;
    {attach_seen, orientation_seen, short_present} = 3'h0;
  end
  // Pins move only just after an edge, so a level is never caught mid-change.
  always @(posedge aclk) begin
    {discharge_request, detach_seen, message_seen} <= want[5:3];
    {attach_seen, orientation_seen, short_present} <= want[2:0];
  end
endmodule // cchc_port_model

// ### testbench/tb.sv
// Self-checking bench for the CC hardware control register block.
`timescale 1ns/1ps
module tb;
  import cchc_pkg::*;
  typedef struct packed {
    logic [31:0] d;
    logic [3:0] s;
    logic [15:0] e;
    logic [15:0] m;
  } cchc_row_t;
  // Role only changes while standalone is off, as software must do.
  localparam cchc_row_t ROWS [5] = '{
    '{32'hffff_ffff, 4'hf, 16'hdebd, 16'hffff},
    '{32'h0000_0005, 4'hf, 16'h0685, 16'hffff},
    '{32'h0000_0004, 4'hf, 16'h0084, 16'hffff},
    '{32'h0000_2002, 4'hf, 16'h0080, 16'hffff},
    '{32'hffff_00ff, 4'h1, 16'h06bd, 16'hffff}
  };
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, match_unit_cycles, q;
  logic [1:0] cfg_sel_pins = 2'h0, power_capability_straps = 2'h0, r, p;
  logic [5:0] want = 6'h0;
  logic message_seen, attach_seen, detach_seen, orientation_seen, short_present;
  logic discharge_request, debouncer_enable, debouncer_pause, port_role_dfp;
  logic vconn_enable, attach_out, orientation_out, discharge_start;
  logic [2:0] detach_threshold_select;
  int n_mismatch = 0, total_checks = 0, n;
  always #50 aclk = ~aclk;
  cchc_ctrl #(.CYCLE_PERIOD_NS(2000)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_sel_pins, .power_capability_straps,
    .message_seen, .attach_seen, .detach_seen, .orientation_seen, .short_present,
    .discharge_request, .debouncer_enable, .debouncer_pause, .detach_threshold_select,
    .match_unit_cycles, .port_role_dfp, .vconn_enable, .attach_out, .orientation_out,
    .discharge_start);
  cchc_port_model partner (.aclk, .want, .discharge_request, .detach_seen, .message_seen,
    .attach_seen, .orientation_seen, .short_present);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] rr);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rr);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Requests discharge with a short present; the short clears at cycle rel.
  task automatic dis(input logic [15:0] v, input int rel, output int c);
    wr(12'h800, {16'h0, v}, 4'hf, r);
    @(posedge aclk);
    want <= 6'h21;
    c = 0;
    while (c < 60 && discharge_start !== 1'b1) begin
      @(posedge aclk);
      c++;
      if (c == rel) want[0] <= 1'b0;
    end
    want <= 6'h00;
    repeat (8) @(posedge aclk);
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    results();
  end
  initial begin
    // Straps set the standalone, role and detach reset values, so each configuration gets its own reset.
    for (int c = 0; c < 4; c++) begin
      p = c[1:0] - 2'd1;
      cfg_sel_pins <= c[1:0];
      power_capability_straps <= p;
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (5) @(posedge aclk);
      rd(12'h800, q, r);
      chk(q, {21'h0, c[1], c[1], 1'b0, p, 1'b0, p, c[0], 1'b0, c[1]});
      rd(12'h804, q, r);
      chk(q, c);
    end
    for (int i = 0; i < 5; i++) begin
      wr(12'h800, ROWS[i].d, ROWS[i].s, r);
      chk(r, 0);
      rd(12'h800, q, r);
      chk(q & {16'hffff, ROWS[i].m}, {16'h0, ROWS[i].e});
      chk({debouncer_enable, port_role_dfp, detach_threshold_select},
        {ROWS[i].e[0], ROWS[i].e[2], ROWS[i].e[5:3]});
      chk(match_unit_cycles, ROWS[i].e[11] ? 32'h3e8 : 32'h3e80);
    end
    wr(12'h808, 32'h1, 4'hf, r);
    chk(r, 2'b10);
    wr(12'h804, 32'h1, 4'hf, r);
    chk(r, 2'b10);
    rd(12'h808, q, r);
    chk(r, 2'b10);
    dis(16'h0005, 99, n);
    chk(n <= 6, 1);
    dis(16'h8005, 30, n);
    chk(n > 30 && n <= 37, 1);
    dis(16'hc005, 99, n);
    chk(n >= 20 && n <= 28, 1);
    dis(16'hc005, 5, n);
    chk(n > 5 && n <= 12, 1);
    dis(16'h8004, 99, n);
    chk(n, 60);
    dis(16'h8001, 99, n);
    chk(n, 60);
    wr(12'h800, 32'h1001, 4'hf, r);
    want <= 6'h0e;
    repeat (6) @(posedge aclk);
    chk({debouncer_pause, attach_out, vconn_enable, orientation_out}, 4'hf);
    rd(12'h800, q, r);
    chk(q[8], 1);
    want <= 6'h18;
    repeat (6) @(posedge aclk);
    chk({debouncer_pause, attach_out, vconn_enable}, 3'b100);
    wr(12'h800, 32'h0, 4'hf, r);
    repeat (4) @(posedge aclk);
    chk({debouncer_pause, debouncer_enable}, 0);
    results();
  end
endmodule // tb
